// *** common/stm_pkg.sv ***
// Purpose: shared constants and types for the 10-bit standard timer
// Assumes: 8-bit register port, 4-bit register address
// Notes: control bit layout mirrors the two control registers
package stm_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_CTRL0 = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_CNT_LO = 4'h2;
    localparam logic [3:0] OFS_CNT_HI = 4'h3;
    localparam logic [3:0] OFS_CMPA_LO = 4'h4;
    localparam logic [3:0] OFS_CMPA_HI = 4'h5;
    localparam logic [3:0] OFS_FLAGS = 4'h6;
    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int RUN_BIT = 3;
    localparam int FLAG_A_BIT = 0;
    localparam int FLAG_P_BIT = 1;
    localparam int COMPARE_P_VALUE_SHIFT = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [9:0] CMPA_RST = 10'h000;
    localparam logic [9:0] CNT_RST = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [7:0] SUB_DIV_MASK = 8'hff;
    localparam logic [5:0] DIV64_MASK = 6'h3f;
    localparam logic [3:0] DIV16_MASK = 4'hf;
    localparam logic [1:0] DIV4_MASK = 2'h3;
    // ----------------------------------------
    // encodings
    // ----------------------------------------
    localparam logic [1:0] OP_CMP = 2'h0;
    localparam logic [1:0] OP_CAP = 2'h1;
    localparam logic [1:0] OP_PWM = 2'h2;
    localparam logic [1:0] OP_TC = 2'h3;
    localparam logic [1:0] IO_NONE = 2'h0;
    localparam logic [1:0] IO_LOW = 2'h1;
    localparam logic [1:0] IO_HIGH = 2'h2;
    localparam logic [1:0] IO_TOGGLE = 2'h3;
    localparam logic [1:0] IO_PWM_INACT = 2'h0;
    localparam logic [1:0] IO_PWM_ACT = 2'h1;
    localparam logic [1:0] IO_PWM_OUT = 2'h2;
    localparam logic [1:0] IO_SINGLE = 2'h3;
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    typedef enum logic [4:0] {
        MODE_CMP = 5'b00001,
        MODE_CAP = 5'b00010,
        MODE_PWM = 5'b00100,
        MODE_SP = 5'b01000,
        MODE_TC = 5'b10000
    } mode_e;
    typedef struct packed {
        logic pause;
        logic [2:0] clk_sel;
        logic run_bit;
        logic [2:0] compare_p_value;
    } ctrl0_s;
    typedef struct packed {
        logic [1:0] op_mode_sel;
        logic [1:0] pin_action;
        logic output_initial_level;
        logic output_invert;
        logic duty_period_swap;
        logic clear_source_sel;
    } ctrl1_s;
    typedef struct packed {
        logic hit_a;
        logic hit_p;
        logic duty_active;
    } match_s;
endpackage

// *** rtl/match_unit.sv ***
// Purpose: comparator A, comparator P and pwm duty decision
// Assumes: counter value is the one that the next tick advances
// Notes: matches look at the value the counter is about to reach
`timescale 1ns/1ps
module match_unit
    import stm_pkg::*;
(
    input wire logic [9:0] cnt_in,
    input wire logic [9:0] cmpa_in,
    input wire logic [2:0] compare_p_value_in,
    input wire logic swap_in,
    output match_s match_out
);
    wire [10:0] cnt_inc = {1'b0, cnt_in} + 11'h001;
    wire compare_p_value_zero = (compare_p_value_in == 3'h0);
    wire [10:0] compare_p_value_span = compare_p_value_zero ? 11'h400 : {1'b0, compare_p_value_in, 7'h00};
    wire [10:0] cmpa_span = {1'b0, cmpa_in};
    wire [10:0] period = swap_in ? cmpa_span : compare_p_value_span;
    wire [10:0] duty = swap_in ? compare_p_value_span : cmpa_span;
    // zero compare A never matches; counter overflows at full range
    assign match_out.hit_a = (cmpa_in != 10'h000) && (cnt_inc[9:0] == cmpa_in);
    // compare P matches when the next count is compare_p_value times 128, or 1024 when it is zero
    assign match_out.hit_p = (cnt_inc[6:0] == 7'h00) &&
        (cnt_inc[10:COMPARE_P_VALUE_SHIFT] == {compare_p_value_zero, compare_p_value_in});
    assign match_out.duty_active = (duty >= period) || ({1'b0, cnt_in} < duty);
endmodule

// *** rtl/standard_timer.sv ***
// Purpose: 10-bit count-up timer with compare, pwm and single pulse modes
// Assumes: one clock, synchronous reset, clock enable freezes all state
// Notes: register map at offsets 0..6 over a plain strobe port
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module standard_timer
    import stm_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic CE_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic EXT_CLOCK_PIN_IN,
    output logic [7:0] RDATA_OUT,
    output logic PIN_OUT,
    output logic PIN_OE_OUT,
    output logic MATCH_A_FLAG_OUT,
    output logic MATCH_P_FLAG_OUT
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    ctrl0_s ctrl0_r;
    ctrl0_s ctrl0_nxt;
    ctrl1_s ctrl1_r;
    logic [9:0] compare_a_value_r;
    logic [9:0] cnt_r;
    logic [9:0] cnt_nxt;
    logic run_prev_r;
    logic match_a_flag_r;
    logic match_p_flag_r;
    logic pin_r;
    logic pin_nxt;
    logic oe_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_mux;
    mode_e mode;
    match_s match;
    logic tick;
    logic ext_edge;

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    wire wr_ctrl0 = WR_IN && (ADDR_IN == OFS_CTRL0);
    wire wr_ctrl1 = WR_IN && (ADDR_IN == OFS_CTRL1);
    wire wr_cmpa_lo = WR_IN && (ADDR_IN == OFS_CMPA_LO);
    wire wr_cmpa_hi = WR_IN && (ADDR_IN == OFS_CMPA_HI);
    wire wr_flags = WR_IN && (ADDR_IN == OFS_FLAGS);
    wire clr_a = wr_flags && WDATA_IN[FLAG_A_BIT];
    wire clr_p = wr_flags && WDATA_IN[FLAG_P_BIT];

    // ----------------------------------------
    // mode decode
    // ----------------------------------------
    always_comb begin
        case (ctrl1_r.op_mode_sel)
            OP_CMP: mode = MODE_CMP;
            OP_CAP: mode = MODE_CAP;
            OP_TC: mode = MODE_TC;
            OP_PWM: mode = (ctrl1_r.pin_action == IO_SINGLE) ? MODE_SP : MODE_PWM;
            default: mode = MODE_CMP;
        endcase
    end
    wire is_cmp = (mode == MODE_CMP);
    wire is_tc = (mode == MODE_TC);
    wire is_cap = (mode == MODE_CAP);
    wire is_pwm = (mode == MODE_PWM);
    wire is_sp = (mode == MODE_SP);
    wire cmp_like = is_cmp || is_tc;

    // ----------------------------------------
    // tick source and comparators
    // ----------------------------------------
    tick_gen u_tick (
        .clk_in(CLK_IN),
        .srst_in(SRST_IN),
        .ce_in(CE_IN),
        .clk_sel_in(ctrl0_r.clk_sel),
        .ext_pin_in(EXT_CLOCK_PIN_IN),
        .tick_out(tick),
        .ext_edge_out(ext_edge)
    );

    match_unit u_match (
        .cnt_in(cnt_r),
        .cmpa_in(compare_a_value_r),
        .compare_p_value_in(ctrl0_r.compare_p_value),
        .swap_in(ctrl1_r.duty_period_swap),
        .match_out(match)
    );

    // ----------------------------------------
    // counting and match events
    // ----------------------------------------
    wire run_rise = ctrl0_r.run_bit && !run_prev_r;
    wire count_en = ctrl0_r.run_bit && !ctrl0_r.pause && tick && !run_rise;
    wire a_ev = count_en && match.hit_a;
    wire p_ev = count_en && match.hit_p;
    // pwm ignores clear source, swap picks the period register
    wire pwm_clr = ctrl1_r.duty_period_swap ? a_ev : p_ev;
    wire cmp_clr = ctrl1_r.clear_source_sel ? a_ev : p_ev;
    wire cnt_clr = (cmp_like && cmp_clr) || (is_pwm && pwm_clr) || (is_cap && p_ev);

    always_comb begin
        cnt_nxt = cnt_r;
        if (run_rise) begin
            cnt_nxt = CNT_RST;
        end else if (count_en) begin
            cnt_nxt = cnt_clr ? CNT_RST : cnt_r + 10'h001;
        end
    end

    // ----------------------------------------
    // flag set terms
    // ----------------------------------------
    wire set_a = (cmp_like || is_pwm || is_sp) && a_ev;
    wire set_p = (is_cmp || is_tc) ? (p_ev && !ctrl1_r.clear_source_sel)
        : ((is_pwm || is_cap) && p_ev);

    // ----------------------------------------
    // run bit and control writes
    // ----------------------------------------
    always_comb begin
        ctrl0_nxt = ctrl0_r;
        if (wr_ctrl0) begin
            ctrl0_nxt = ctrl0_s'(WDATA_IN);
        end
        if (is_sp && a_ev) begin
            ctrl0_nxt.run_bit = 1'b0;
        end
        if (is_sp && ext_edge) begin
            ctrl0_nxt.run_bit = 1'b1;
        end
    end

    // ----------------------------------------
    // output pin level
    // ----------------------------------------
    wire lvl_on = ctrl1_r.output_initial_level ^ ctrl1_r.output_invert;
    wire lvl_off = ~ctrl1_r.output_initial_level ^ ctrl1_r.output_invert;
    wire pwm_on = (ctrl1_r.pin_action == IO_PWM_ACT) ||
        ((ctrl1_r.pin_action == IO_PWM_OUT) && match.duty_active);
    wire sp_on = ctrl0_nxt.run_bit;

    always_comb begin
        pin_nxt = pin_r;
        case (mode)
            MODE_CMP: begin
                if (run_rise) begin
                    pin_nxt = ctrl1_r.output_initial_level;
                end else if (a_ev) begin
                    case (ctrl1_r.pin_action)
                        IO_NONE: pin_nxt = pin_r;
                        IO_LOW: pin_nxt = 1'b0;
                        IO_HIGH: pin_nxt = 1'b1;
                        IO_TOGGLE: pin_nxt = ~pin_r;
                        default: pin_nxt = pin_r;
                    endcase
                end
            end
            MODE_PWM: pin_nxt = pwm_on ? lvl_on : lvl_off;
            MODE_SP: pin_nxt = sp_on ? lvl_on : lvl_off;
            MODE_TC: pin_nxt = pin_r;
            MODE_CAP: pin_nxt = pin_r;
            default: pin_nxt = pin_r;
        endcase
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        case (ADDR_IN)
            OFS_CTRL0: rd_mux = ctrl0_r;
            OFS_CTRL1: rd_mux = ctrl1_r;
            OFS_CNT_LO: rd_mux = cnt_r[7:0];
            OFS_CNT_HI: rd_mux = {6'h00, cnt_r[9:8]};
            OFS_CMPA_LO: rd_mux = compare_a_value_r[7:0];
            OFS_CMPA_HI: rd_mux = {6'h00, compare_a_value_r[9:8]};
            OFS_FLAGS: rd_mux = {6'h00, match_p_flag_r, match_a_flag_r};
            default: rd_mux = 8'h00;
        endcase
    end

    // ----------------------------------------
    // control and compare registers
    // ----------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            ctrl0_r <= ctrl0_s'(CTRL_RST);
            ctrl1_r <= ctrl1_s'(CTRL_RST);
            compare_a_value_r <= CMPA_RST;
        end else if (CE_IN) begin
            ctrl0_r <= ctrl0_nxt;
            if (wr_ctrl1) begin
                ctrl1_r <= ctrl1_s'(WDATA_IN);
            end
            if (wr_cmpa_lo) begin
                compare_a_value_r[7:0] <= WDATA_IN;
            end
            if (wr_cmpa_hi) begin
                compare_a_value_r[9:8] <= WDATA_IN[1:0];
            end
        end
    end

    // ----------------------------------------
    // counter and run history
    // ----------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            cnt_r <= CNT_RST;
            run_prev_r <= 1'b0;
        end else if (CE_IN) begin
            cnt_r <= cnt_nxt;
            run_prev_r <= ctrl0_r.run_bit;
        end
    end

    // ----------------------------------------
    // sticky flags, set wins over clear
    // ----------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            match_a_flag_r <= 1'b0;
            match_p_flag_r <= 1'b0;
        end else if (CE_IN) begin
            match_a_flag_r <= set_a || (match_a_flag_r && !clr_a);
            match_p_flag_r <= set_p || (match_p_flag_r && !clr_p);
        end
    end

    // ----------------------------------------
    // pin, enable and read data
    // ----------------------------------------
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            pin_r <= 1'b0;
            oe_r <= 1'b0;
            rdata_r <= 8'h00;
        end else if (CE_IN) begin
            pin_r <= pin_nxt;
            oe_r <= is_cmp || is_pwm || is_sp;
            rdata_r <= RD_IN ? rd_mux : 8'h00;
        end
    end

    assign RDATA_OUT = rdata_r;
    assign PIN_OUT = pin_r;
    assign PIN_OE_OUT = oe_r;
    assign MATCH_A_FLAG_OUT = match_a_flag_r;
    assign MATCH_P_FLAG_OUT = match_p_flag_r;
endmodule

// *** rtl/tick_gen.sv ***
// Purpose: timer tick selection and external pin edge detect
// Assumes: external clock pin is synchronous to the clock
// Notes: sub clock is modelled as a divide by 256
`timescale 1ns/1ps
module tick_gen
    import stm_pkg::*;
(
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic ce_in,
    input wire logic [2:0] clk_sel_in,
    input wire logic ext_pin_in,
    output logic tick_out,
    output logic ext_edge_out
);
    logic [7:0] div_r;
    logic ext_prev_r;
    wire ext_rise = ext_pin_in & ~ext_prev_r;
    wire ext_fall = ~ext_pin_in & ext_prev_r;
    wire ext_pick = clk_sel_in[0] ? ext_fall : ext_rise;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            div_r <= 8'h00;
            ext_prev_r <= 1'b0;
        end else if (ce_in) begin
            div_r <= div_r + 8'h01;
            ext_prev_r <= ext_pin_in;
        end
    end
    // active edge follows the rise/fall choice of the clock select
    assign ext_edge_out = ext_pick;
    always_comb begin
        case (clk_sel_in)
            CK_SYS4: tick_out = (div_r[1:0] == DIV4_MASK);
            CK_SYS: tick_out = 1'b1;
            CK_H16: tick_out = (div_r[3:0] == DIV16_MASK);
            CK_H64: tick_out = (div_r[5:0] == DIV64_MASK);
            CK_SUB0, CK_SUB1: tick_out = (div_r == SUB_DIV_MASK);
            CK_EXT_RISE, CK_EXT_FALL: tick_out = ext_pick;
            default: tick_out = 1'b0;
        endcase
    end
endmodule

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the standard timer
// Assumes: clock enable dropped once, ext pin as tick and trigger
// Notes: reads are scored through an expectation queue
`timescale 1ns/1ps
module testbench
    import stm_pkg::*;
;
    logic CLK_IN = 1'b0;
    logic SRST_IN = 1'b1;
    logic CE_IN = 1'b1;
    logic [3:0] ADDR_IN = 4'h0;
    logic [7:0] WDATA_IN = 8'h00;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic EXT_CLOCK_PIN_IN = 1'b0;
    logic [7:0] RDATA_OUT;
    logic PIN_OUT, PIN_OE_OUT, MATCH_A_FLAG_OUT, MATCH_P_FLAG_OUT;
    int n_fail = 0;
    int n_compared = 0;
    integer seed = 32'h2e92;
    logic [15:0] exp_q[$];
    logic [15:0] ent;
    logic rd_q = 1'b0;
    logic oc, pe;
    logic [9:0] n_cnt, hi_n;
    logic [7:0] pw_c1 [6] = '{8'ha9, 8'had, 8'ha9, 8'hab, 8'h89, 8'h99};
    logic [9:0] pw_a [6] = '{10'd32, 10'd32, 10'd200, 10'd100, 10'd32, 10'd32};
    logic [9:0] pw_n [6] = '{10'd64, 10'd192, 10'd256, 10'd256, 10'd0, 10'd256};
    logic [9:0] ck_n [6] = '{10'd320, 10'd256, 10'd80, 10'd20, 10'd5, 10'd5};
    always #5 CLK_IN = ~CLK_IN;
    standard_timer dut (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN),
        .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
        .EXT_CLOCK_PIN_IN(EXT_CLOCK_PIN_IN), .RDATA_OUT(RDATA_OUT), .PIN_OUT(PIN_OUT),
        .PIN_OE_OUT(PIN_OE_OUT), .MATCH_A_FLAG_OUT(MATCH_A_FLAG_OUT),
        .MATCH_P_FLAG_OUT(MATCH_P_FLAG_OUT));
    // ----------------
    // helpers
    // ----------------
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        WDATA_IN <= d;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge CLK_IN);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        exp_q.push_back({m, e});
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
    endtask
    task automatic seta(input logic [9:0] a);
        wr(OFS_CMPA_LO, a[7:0]);
        wr(OFS_CMPA_HI, {6'h00, a[9:8]});
    endtask
    task automatic start(input logic [7:0] c1, input logic [7:0] c0);
        wr(OFS_CTRL0, c0);
        wr(OFS_CTRL1, c1);
        wr(OFS_FLAGS, 8'h03);
        wr(OFS_CTRL0, c0 | 8'h08);
    endtask
    task automatic pulse(input int n);
        repeat (3) @(posedge CLK_IN);
        repeat (n) begin
            @(posedge CLK_IN);
            EXT_CLOCK_PIN_IN <= 1'b1;
            @(posedge CLK_IN);
            EXT_CLOCK_PIN_IN <= 1'b0;
        end
        repeat (4) @(posedge CLK_IN);
    endtask
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge CLK_IN) rd_q <= RD_IN;
    always @(negedge CLK_IN) begin
        if (rd_q) begin
            ent = exp_q.pop_front();
            check({2'b00, RDATA_OUT & ent[15:8]}, {2'b00, ent[7:0] & ent[15:8]});
        end
    end
    initial begin
        #500000;
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test();
    end
    // ----------------
    // scenarios
    // ----------------
    initial begin
        repeat (16) @(posedge CLK_IN);
        SRST_IN <= 1'b0;
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(OFS_CMPA_HI, 8'h00, 8'hff);
        wr(OFS_CNT_HI, 8'hff);
        wr(4'hf, 8'hff);
        seta(10'h3a5);
        wr(OFS_CMPA_HI, 8'hff);
        rd(OFS_CMPA_LO, 8'ha5, 8'hff);
        rd(OFS_CMPA_HI, 8'h03, 8'hff);
        rd(OFS_CNT_HI, 8'h00, 8'hff);
        rd(4'hf, 8'h00, 8'hff);
        n_cnt = 10'd200 + {2'b00, 8'($random(seed))};
        seta(10'h3ff);
        start(8'hc0, 8'h60);
        pulse(n_cnt);
        rd(OFS_CNT_LO, n_cnt[7:0], 8'hff);
        rd(OFS_CNT_HI, {6'h00, n_cnt[9:8]}, 8'hff);
        check({9'h0, PIN_OE_OUT}, 10'h000);
        CE_IN <= 1'b0;
        pulse(5);
        CE_IN <= 1'b1;
        rd(OFS_CNT_LO, n_cnt[7:0], 8'hff);
        wr(OFS_CTRL0, 8'he8);
        pulse(5);
        rd(OFS_CNT_LO, n_cnt[7:0], 8'hff);
        wr(OFS_CTRL0, 8'h60);
        pulse(5);
        rd(OFS_CNT_LO, n_cnt[7:0], 8'hff);
        wr(OFS_CTRL0, 8'h68);
        repeat (3) @(posedge CLK_IN);
        rd(OFS_CNT_LO, 8'h00, 8'hff);
        seta(10'h000);
        start(8'hc0, 8'h70);
        pulse(1030);
        rd(OFS_CNT_LO, 8'h06, 8'hff);
        rd(OFS_FLAGS, 8'h00, 8'h01);
        seta(10'd50);
        start(8'hc0, 8'h61);
        pulse(200);
        rd(OFS_CNT_LO, 8'd72, 8'hff);
        rd(OFS_FLAGS, 8'h03, 8'hff);
        seta(10'd300);
        start(8'hc1, 8'h61);
        pulse(350);
        rd(OFS_FLAGS, 8'h01, 8'hff);
        check({8'h00, MATCH_P_FLAG_OUT, MATCH_A_FLAG_OUT}, 10'h001);
        seta(10'd50);
        start(8'h41, 8'h61);
        pulse(200);
        rd(OFS_CNT_LO, 8'd72, 8'hff);
        rd(OFS_FLAGS, 8'h02, 8'hff);
        check({9'h0, PIN_OE_OUT}, 10'h000);
        for (int cs = 0; cs < 6; cs++) begin
            start(8'hc0, {1'b0, 3'(cs), 4'h0});
            repeat (1279) @(posedge CLK_IN);
            wr(OFS_CTRL0, {1'b0, 3'(cs), 4'h0});
            rd(OFS_CNT_LO, ck_n[cs][7:0], 8'hff);
            rd(OFS_CNT_HI, {6'h00, ck_n[cs][9:8]}, 8'hff);
        end
        seta(10'd5);
        for (int io = 0; io < 4; io++) begin
            oc = 1'($random(seed));
            start({2'b00, 2'(io), oc, 3'b000}, 8'h61);
            repeat (4) @(posedge CLK_IN);
            check({9'h0, PIN_OUT}, {9'h0, oc});
            check({9'h0, PIN_OE_OUT}, 10'h001);
            pulse(5);
            pe = (io == 0) ? oc : (io == 1) ? 1'b0 : (io == 2) ? 1'b1 : ~oc;
            check({9'h0, PIN_OUT}, {9'h0, pe});
            pulse(125);
            check({9'h0, PIN_OUT}, {9'h0, pe});
            rd(OFS_FLAGS, 8'h03, 8'hff);
            check({8'h00, MATCH_P_FLAG_OUT, MATCH_A_FLAG_OUT}, 10'h003);
        end
        for (int i = 0; i < 6; i++) begin
            seta(pw_a[i]);
            start(pw_c1[i], 8'h11);
            repeat (20) @(posedge CLK_IN);
            hi_n = '0;
            repeat (256) begin
                @(negedge CLK_IN);
                hi_n = hi_n + {9'h0, PIN_OUT};
            end
            check(hi_n, pw_n[i]);
            if (i == 0) rd(OFS_FLAGS, 8'h03, 8'hff);
        end
        seta(10'd10);
        start(8'hb8, 8'h00);
        repeat (4) @(posedge CLK_IN);
        check({9'h0, PIN_OUT}, 10'h001);
        repeat (50) @(posedge CLK_IN);
        check({9'h0, PIN_OUT}, 10'h000);
        rd(OFS_CTRL0, 8'h00, 8'hff);
        rd(OFS_FLAGS, 8'h01, 8'h01);
        rd(OFS_CNT_LO, 8'h0a, 8'hff);
        pulse(1);
        rd(OFS_CTRL0, 8'h08, 8'hff);
        check({9'h0, PIN_OUT}, 10'h001);
        wr(OFS_CTRL0, 8'h00);
        repeat (3) @(posedge CLK_IN);
        check({9'h0, PIN_OUT}, 10'h000);
        repeat (4) @(posedge CLK_IN);
        end_of_test();
    end
endmodule

// *** tb/timer_properties.sv ***
// Purpose: port-level checks for the standard timer
// Assumes: shadows follow writes taken with clock enable high
// Notes: control bits are shadowed from bus writes
`timescale 1ns/1ps
module timer_checker
    import stm_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic SRST_IN,
    input wire logic CE_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [7:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    input wire logic EXT_CLOCK_PIN_IN,
    input wire logic [7:0] RDATA_OUT,
    input wire logic PIN_OUT,
    input wire logic PIN_OE_OUT,
    input wire logic MATCH_A_FLAG_OUT,
    input wire logic MATCH_P_FLAG_OUT
);
    // ----------------
    // control shadows
    // ----------------
    ctrl1_s c1_r;
    logic run_r;
    wire wr_c0 = WR_IN && CE_IN && ADDR_IN == OFS_CTRL0;
    wire wr_c1 = WR_IN && CE_IN && ADDR_IN == OFS_CTRL1;
    wire wr_fl = WR_IN && CE_IN && ADDR_IN == OFS_FLAGS;
    wire clr_a = wr_fl && WDATA_IN[FLAG_A_BIT];
    wire clr_p = wr_fl && WDATA_IN[FLAG_P_BIT];
    wire a_only = (c1_r.op_mode_sel[1] == c1_r.op_mode_sel[0]) && c1_r.clear_source_sel;
    wire tc_mode = c1_r.op_mode_sel == OP_TC;
    wire forced = c1_r.op_mode_sel == OP_PWM && !c1_r.pin_action[1] && run_r;
    wire lvl = (c1_r.pin_action[0] ~^ c1_r.output_initial_level) ^ c1_r.output_invert;
    wire run_go = wr_c0 && WDATA_IN[RUN_BIT] && !run_r && c1_r.op_mode_sel == OP_CMP;
    always_ff @(posedge CLK_IN) begin
        if (SRST_IN) begin
            c1_r <= '0;
            run_r <= 1'b0;
        end else begin
            if (wr_c1) c1_r <= ctrl1_s'(WDATA_IN);
            if (wr_c0) run_r <= WDATA_IN[RUN_BIT];
        end
    end
    // ----------------
    // properties
    // ----------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);
    rdata_idle_a: assert property (!RD_IN && CE_IN |=> RDATA_OUT == 8'h00)
        else $error("read data not idle");
    cnt_hi_pad_a: assert property (RD_IN && ADDR_IN == OFS_CNT_HI |=> RDATA_OUT[7:2] == 6'h00)
        else $error("counter high byte padding set");
    cmpa_hi_pad_a: assert property (RD_IN && ADDR_IN == OFS_CMPA_HI |=> RDATA_OUT[7:2] == 6'h00)
        else $error("compare high byte padding set");
    reset_clear_a: assert property ($fell(SRST_IN) |-> !PIN_OUT && !PIN_OE_OUT
        && !MATCH_A_FLAG_OUT && !MATCH_P_FLAG_OUT && RDATA_OUT == 8'h00)
        else $error("outputs not cleared by reset");
    flag_a_hold_a: assert property (MATCH_A_FLAG_OUT && !clr_a |=> MATCH_A_FLAG_OUT)
        else $error("match a flag dropped");
    flag_p_hold_a: assert property (MATCH_P_FLAG_OUT && !clr_p |=> MATCH_P_FLAG_OUT)
        else $error("match p flag dropped");
    no_p_flag_a: assert property (a_only [*2] ##0 !MATCH_P_FLAG_OUT |=> !MATCH_P_FLAG_OUT)
        else $error("p flag raised with clear on a");
    tc_no_drive_a: assert property (tc_mode [*3] |-> !PIN_OE_OUT)
        else $error("pin driven in timer mode");
    pwm_forced_a: assert property (forced [*4] |-> PIN_OUT == lvl)
        else $error("forced pwm level wrong");
    run_init_a: assert property (run_go |-> ##3 PIN_OUT == c1_r.output_initial_level)
        else $error("pin not at initial level");
    cover property ($rose(MATCH_A_FLAG_OUT));
    cover property ($rose(MATCH_P_FLAG_OUT));
    cover property ($rose(PIN_OUT));
    cover property ($rose(EXT_CLOCK_PIN_IN) ##2 PIN_OUT);
endmodule
bind standard_timer timer_checker u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN),
    .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
    .EXT_CLOCK_PIN_IN(EXT_CLOCK_PIN_IN), .RDATA_OUT(RDATA_OUT), .PIN_OUT(PIN_OUT),
    .PIN_OE_OUT(PIN_OE_OUT), .MATCH_A_FLAG_OUT(MATCH_A_FLAG_OUT),
    .MATCH_P_FLAG_OUT(MATCH_P_FLAG_OUT));
